/* File: hdl/sbc_wakeup_watchdog_reset.sv */
// How it works
// - In Stop, an enabled wake source moves to normal-request and pulses irq.
// - Chip-select rising edge wakes the device from Sleep or Stop.
// - Stop overcurrent wakes to normal-request with unmaskable irq, no flag.
// - Stop wake enters normal-request first, then a 10 us irq pulse.
// - Bus wake and input wake set flags; overcurrent and timed set none.
// - SPI access is refused until the first-access delay after the pulse.
// - Watchdog expiry in Stop asserts reset, then normal-request follows.
// - Stop command takes effect on the chip-select rising edge.
// - Overcurrent wake is blanked for 40 us after Stop entry.
// - Watchdog runs in Normal and Standby; window mode by default.
// - Two select bits pick a period of 10 ms to 350 ms.
// - Service during the closed window causes reset; open window restarts.
// - Low supply holds reset low until supply recovers; fault stays high.
// - At power-on and Sleep wake, reset stays low until supply is good.
// - Watchdog expiry drives reset low for the fixed reset duration.
// - Watchdog fault output falls with the reset, held until good service.
// - Wake cause is recorded; Sleep wake re-enables the regulator.
// - Direct wake needs the 0xx0 control pattern set by the host.
// - Input sensitivity is configured per pair of wake inputs.
// - Pattern 1xx1 selects cyclic sense with the timed switch bias.
// - Timed wake and cyclic sense exclude each other.
// - Normal-request times out after 350 ms to reset or back to Sleep.
`timescale 1ns/1ps
module sbc_wakeup_watchdog_reset #(
    parameter int BLANK_CYC = sbc_pkg::T_BLANK_NS / sbc_pkg::CLK_NS,
    parameter int NREQ_CYC =
        sbc_pkg::T_NREQ_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int RST_CYC =
        sbc_pkg::T_RST_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int FIRST_SPI_CYC =
        sbc_pkg::T_FIRST_SPI_US * (sbc_pkg::NS_PER_US / sbc_pkg::CLK_NS),
    parameter int TIMED_CYC =
        sbc_pkg::T_TIMED_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int CYC_CYC =
        sbc_pkg::T_CYC_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int BIAS_ON_CYC =
        sbc_pkg::T_BIAS_ON_US * (sbc_pkg::NS_PER_US / sbc_pkg::CLK_NS),
    parameter int WD0_CYC =
        sbc_pkg::T_WD0_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int WD1_CYC =
        sbc_pkg::T_WD1_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int WD2_CYC =
        sbc_pkg::T_WD2_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS),
    parameter int WD3_CYC =
        sbc_pkg::T_WD3_MS * (sbc_pkg::NS_PER_MS / sbc_pkg::CLK_NS)
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic cmd_stop,
    input wire logic cmd_sleep,
    input wire logic cmd_normal,
    input wire logic cmd_standby,
    input wire logic tim_write,
    input wire logic window_select,
    input wire logic period_select_lo,
    input wire logic period_select_hi,
    input wire logic stop_watchdog_enable,
    input wire logic [3:0] low_power_control,
    input wire logic [1:0] wake_sense,
    input wire logic [3:0] wake_inputs,
    input wire logic bus_wake,
    input wire logic overcurrent,
    input wire logic vdd_good,
    input wire logic flag_clear,
    output logic mcu_reset_out_b,
    output logic watchdog_fault_out_b,
    output logic irq_out_pin_b,
    output logic spi_ready,
    output logic main_regulator_en,
    output logic high_side_switch,
    output logic bus_wake_flag,
    output logic [3:0] input_wake_flag,
    output sbc_pkg::mode_e mode
);
    localparam int W = sbc_pkg::CNT_W;
    localparam int A_IRQ = sbc_pkg::IRQ_CYC;

    logic rst_q1, rst_n;
    logic [sbc_pkg::N_SYNC-1:0] sy1, sy2;
    logic cs_prev, cs_rise;
    logic [W-1:0] tmr, wd_cnt, lp_cnt, cyc_cnt, spi_wait, wd_period;
    logic stop_pend, sleep_pend, from_sleep, irq_arm;
    logic tim_ok, wd_run, wd_bad, wd_expire, closed;
    logic low_power, direct, cyclic_mode, cyclic_on, timed_on;
    logic blank_done, oc_wake, timed_wake, cyc_sample, cs_wake;
    logic [3:0] in_wake;
    logic lp_wake, stop_wake;

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // Pins come from outside this clock domain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sy1 <= 8'hd0;
            sy2 <= 8'hd0;
            cs_prev <= 1'b1;
        end else begin
            sy1 <= {vdd_good, overcurrent, bus_wake, cs_b, wake_inputs};
            sy2 <= sy1;
            cs_prev <= sy2[sbc_pkg::SY_CS];
        end
    end

    assign cs_rise = sy2[sbc_pkg::SY_CS] && !cs_prev;

    always_comb begin
        unique case ({period_select_hi, period_select_lo})
            2'h0: wd_period = W'(WD0_CYC);
            2'h1: wd_period = W'(WD1_CYC);
            2'h2: wd_period = W'(WD2_CYC);
            2'h3: wd_period = W'(WD3_CYC);
        endcase
    end

    // SPI service is honoured only once the first-access delay is over
    assign tim_ok = tim_write && spi_ready;
    assign wd_run = (mode == sbc_pkg::M_NORMAL)
        || (mode == sbc_pkg::M_STANDBY)
        || (mode == sbc_pkg::M_STOP && stop_watchdog_enable);
    assign closed = wd_cnt < (wd_period >> sbc_pkg::WIN_SHIFT);
    // The window does not apply in Stop, where service means waking
    assign wd_bad = tim_ok && window_select && closed
        && (mode == sbc_pkg::M_NORMAL || mode == sbc_pkg::M_STANDBY);
    assign wd_expire = (wd_run && wd_cnt >= wd_period - W'(1)) || wd_bad;

    // Wake source selection in low power
    assign low_power = (mode == sbc_pkg::M_STOP)
        || (mode == sbc_pkg::M_SLEEP);
    assign direct = !low_power_control[sbc_pkg::LP_BIAS]
        && !low_power_control[sbc_pkg::LP_AUTO];
    assign cyclic_mode = low_power_control[sbc_pkg::LP_BIAS]
        && low_power_control[sbc_pkg::LP_AUTO];
    // When both are requested neither runs, so neither is trusted
    assign cyclic_on = cyclic_mode
        && !low_power_control[sbc_pkg::LP_TWE];
    assign timed_on = low_power_control[sbc_pkg::LP_TWE]
        && !cyclic_mode;
    assign cyc_sample = cyc_cnt == W'(BIAS_ON_CYC - 1);
    assign blank_done = lp_cnt >= W'(BLANK_CYC);
    assign oc_wake = (mode == sbc_pkg::M_STOP) && blank_done
        && sy2[sbc_pkg::SY_OC];
    assign timed_wake = low_power && timed_on
        && lp_cnt >= W'(TIMED_CYC - 1);
    assign cs_wake = low_power && cs_rise;

    wake_input_detect u_wake (
        .level(sy2[3:0]),
        .sense(wake_sense),
        .enable(low_power && (direct || cyclic_on)),
        .sample(direct || cyc_sample),
        .wake(in_wake)
    );

    assign lp_wake = low_power && (cs_wake || timed_wake || oc_wake
        || sy2[sbc_pkg::SY_BUS] || (|in_wake));
    assign stop_wake = lp_wake && (mode == sbc_pkg::M_STOP);

    // Operating mode and its timer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= sbc_pkg::M_RESET;
            tmr <= '0;
            from_sleep <= 1'b0;
        end else if (!sy2[sbc_pkg::SY_VDD]
                && mode != sbc_pkg::M_SLEEP) begin
            mode <= sbc_pkg::M_RESET;
            tmr <= '0;
        end else begin
            unique case (mode)
                sbc_pkg::M_RESET: begin
                    if (tmr >= W'(RST_CYC - 1)) begin
                        mode <= sbc_pkg::M_NREQ;
                        tmr <= '0;
                    end else begin
                        tmr <= tmr + W'(1);
                    end
                end
                sbc_pkg::M_NREQ: begin
                    if (tim_ok) begin
                        mode <= sbc_pkg::M_NORMAL;
                        from_sleep <= 1'b0;
                    end else if (tmr >= W'(NREQ_CYC - 1)) begin
                        mode <= from_sleep ? sbc_pkg::M_SLEEP
                            : sbc_pkg::M_RESET;
                    end
                    tmr <= tmr + W'(1);
                end
                sbc_pkg::M_NORMAL, sbc_pkg::M_STANDBY: begin
                    tmr <= '0;
                    if (wd_expire) begin
                        mode <= sbc_pkg::M_RESET;
                    end else if (cs_rise && stop_pend) begin
                        mode <= sbc_pkg::M_STOP;
                    end else if (cs_rise && sleep_pend) begin
                        mode <= sbc_pkg::M_SLEEP;
                    end else if (cmd_standby) begin
                        mode <= sbc_pkg::M_STANDBY;
                    end else if (cmd_normal) begin
                        mode <= sbc_pkg::M_NORMAL;
                    end
                end
                sbc_pkg::M_STOP: begin
                    tmr <= '0;
                    if (wd_expire) begin
                        mode <= sbc_pkg::M_RESET;
                    end else if (stop_wake) begin
                        mode <= sbc_pkg::M_NREQ;
                        from_sleep <= 1'b0;
                    end
                end
                sbc_pkg::M_SLEEP: begin
                    tmr <= '0;
                    if (lp_wake) begin
                        mode <= sbc_pkg::M_RESET;
                        from_sleep <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Low-power commands wait for the end of their SPI frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_pend <= 1'b0;
            sleep_pend <= 1'b0;
        end else if (cs_rise) begin
            stop_pend <= 1'b0;
            sleep_pend <= 1'b0;
        end else begin
            if (cmd_stop) begin
                stop_pend <= 1'b1;
            end
            if (cmd_sleep) begin
                sleep_pend <= 1'b1;
            end
        end
    end

    // Watchdog counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wd_cnt <= '0;
        end else if (!wd_run || wd_expire || tim_ok) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= wd_cnt + W'(1);
        end
    end

    // Fault output; a new fault wins over a service in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            watchdog_fault_out_b <= 1'b1;
        end else if (wd_expire && mode != sbc_pkg::M_SLEEP
                && sy2[sbc_pkg::SY_VDD]) begin
            watchdog_fault_out_b <= 1'b0;
        end else if (tim_ok) begin
            watchdog_fault_out_b <= 1'b1;
        end
    end

    // Reset pin low in Reset, in Sleep and whenever supply is low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mcu_reset_out_b <= 1'b0;
        end else begin
            mcu_reset_out_b <= sy2[sbc_pkg::SY_VDD]
                && mode != sbc_pkg::M_RESET
                && mode != sbc_pkg::M_SLEEP
                && !(wd_expire && mode != sbc_pkg::M_SLEEP);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            main_regulator_en <= 1'b1;
        end else begin
            main_regulator_en <= mode != sbc_pkg::M_SLEEP;
        end
    end

    // Low-power timers: blanking, timed wake and cyclic sense period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lp_cnt <= '0;
            cyc_cnt <= '0;
            high_side_switch <= 1'b0;
        end else if (!low_power) begin
            lp_cnt <= '0;
            cyc_cnt <= '0;
            high_side_switch <= 1'b0;
        end else begin
            if (lp_cnt != {W{1'b1}}) begin
                lp_cnt <= lp_cnt + W'(1);
            end
            if (cyc_cnt >= W'(CYC_CYC - 1)) begin
                cyc_cnt <= '0;
            end else begin
                cyc_cnt <= cyc_cnt + W'(1);
            end
            high_side_switch <= cyclic_on
                && cyc_cnt < W'(BIAS_ON_CYC - 1);
        end
    end

    // Wake cause; a new wake wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_wake_flag <= 1'b0;
            input_wake_flag <= 4'h0;
        end else begin
            bus_wake_flag <= (bus_wake_flag && !flag_clear)
                || (lp_wake && sy2[sbc_pkg::SY_BUS]);
            input_wake_flag <= (input_wake_flag & {4{!flag_clear}})
                | (lp_wake ? in_wake : 4'h0);
        end
    end

    // One counter covers the irq pulse and the first-access delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_arm <= 1'b0;
            spi_wait <= '0;
            irq_out_pin_b <= 1'b1;
            spi_ready <= 1'b1;
        end else if (mode == sbc_pkg::M_RESET) begin
            irq_arm <= 1'b0;
            spi_wait <= '0;
            irq_out_pin_b <= 1'b1;
            spi_ready <= 1'b1;
        end else if (stop_wake && !wd_expire) begin
            irq_arm <= 1'b1;
        end else if (irq_arm && mode == sbc_pkg::M_NREQ) begin
            irq_arm <= 1'b0;
            spi_wait <= W'(sbc_pkg::IRQ_CYC + FIRST_SPI_CYC);
            irq_out_pin_b <= 1'b0;
            spi_ready <= 1'b0;
        end else if (spi_wait != '0) begin
            spi_wait <= spi_wait - W'(1);
            irq_out_pin_b <= spi_wait <= W'(FIRST_SPI_CYC + 1);
            spi_ready <= spi_wait == W'(1);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_wd_reset;
        (mode == sbc_pkg::M_RESET && !watchdog_fault_out_b)
            ##0 !mcu_reset_out_b;
    endsequence

    // Pulse is too long to unroll as a delay, so its width is counted
    logic [W-1:0] irq_low_len;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_low_len <= '0;
        end else if (irq_out_pin_b) begin
            irq_low_len <= '0;
        end else begin
            irq_low_len <= irq_low_len + W'(1);
        end
    end

    a_stop_wake_nreq: assert property (
        (mode == sbc_pkg::M_STOP && stop_wake && !wd_expire
            && sy2[sbc_pkg::SY_VDD]) |=> mode == sbc_pkg::M_NREQ)
        else $error("Stop wake did not reach normal-request");
    a_cs_wake_sleep: assert property (
        (mode == sbc_pkg::M_SLEEP && cs_rise)
            |=> mode == sbc_pkg::M_RESET ##1 !mcu_reset_out_b)
        else $error("Chip-select edge did not wake from Sleep");
    a_irq_width: assert property (
        $rose(irq_out_pin_b) && mode != sbc_pkg::M_RESET
            |-> irq_low_len == W'(A_IRQ))
        else $error("Wake interrupt pulse width wrong");
    a_irq_order: assert property (
        $fell(irq_out_pin_b) |-> $past(mode) == sbc_pkg::M_NREQ
            && mcu_reset_out_b)
        else $error("Interrupt pulse outside normal-request");
    a_spi_hold: assert property (
        $rose(irq_out_pin_b) |-> !spi_ready [*3])
        else $error("SPI accepted right after the pulse");
    a_stop_on_edge: assert property (
        (mode == sbc_pkg::M_NORMAL && !cs_rise && !wd_expire)
            |=> mode != sbc_pkg::M_STOP)
        else $error("Stop entered without chip-select edge");
    a_blank_oc: assert property (
        $rose(mode == sbc_pkg::M_STOP) |-> !oc_wake [*8])
        else $error("Overcurrent wake inside blanking");
    a_window_reset: assert property (
        (tim_ok && window_select && closed && sy2[sbc_pkg::SY_VDD]
            && mode == sbc_pkg::M_NORMAL) |=> s_wd_reset)
        else $error("Closed-window service did not reset");
    a_vdd_low_reset: assert property (
        !sy2[sbc_pkg::SY_VDD] |=> !mcu_reset_out_b)
        else $error("Reset not low while supply is low");
    a_fault_hold: assert property (
        (!watchdog_fault_out_b && !tim_write) |=> !watchdog_fault_out_b)
        else $error("Fault output released without service");
    a_nreq_timeout: assert property (
        (mode == sbc_pkg::M_NREQ && tmr == W'(NREQ_CYC - 1) && !tim_ok
            && sy2[sbc_pkg::SY_VDD])
            |=> mode inside {sbc_pkg::M_RESET, sbc_pkg::M_SLEEP})
        else $error("Normal-request did not time out");
endmodule // sbc_wakeup_watchdog_reset

/* File: shared/sbc_pkg.sv */
package sbc_pkg;
    // Base clock: 125 MHz
    localparam int CLK_NS = 8;
    localparam int NS_PER_US = 1000;
    localparam int NS_PER_MS = 1000000;
    localparam int CNT_W = 26;

    // Wake interrupt pulse, about 10 us
    localparam int T_IRQ_NS = 10000;
    localparam int IRQ_CYC = T_IRQ_NS / CLK_NS;
    // Overcurrent blanking after Stop entry, about 40 us
    localparam int T_BLANK_NS = 40000;
    // Normal-request configuration timeout
    localparam int T_NREQ_MS = 350;
    // Watchdog periods selected by period_select_hi/lo
    localparam int T_WD0_MS = 10;
    localparam int T_WD1_MS = 45;
    localparam int T_WD2_MS = 100;
    localparam int T_WD3_MS = 350;
    // Reset duration, first-SPI delay, timed wake, cyclic sense
    localparam int T_RST_MS = 10;
    localparam int T_FIRST_SPI_US = 100;
    localparam int T_TIMED_MS = 200;
    localparam int T_CYC_MS = 20;
    localparam int T_BIAS_ON_US = 200;

    // Closed window is the first half of the period
    localparam int WIN_SHIFT = 1;

    // Field positions in low_power_control
    localparam int LP_BIAS = 3;
    localparam int LP_TWE = 1;
    localparam int LP_AUTO = 0;

    localparam int N_WAKE = 4;
    localparam int N_SYNC = 8;
    // Positions in the synchroniser vector
    localparam int SY_CS = 4;
    localparam int SY_BUS = 5;
    localparam int SY_OC = 6;
    localparam int SY_VDD = 7;

    typedef enum logic [2:0] {
        M_RESET,
        M_NREQ,
        M_NORMAL,
        M_STANDBY,
        M_STOP,
        M_SLEEP
    } mode_e;
endpackage

/* File: hdl/wake_input_detect.sv */
`timescale 1ns/1ps
module wake_input_detect (
    input wire logic [3:0] level,
    input wire logic [1:0] sense,
    input wire logic enable,
    input wire logic sample,
    output logic [3:0] wake
);
    // Sensitivity is shared per pair of inputs
    genvar i;
    generate
        for (i = 0; i < sbc_pkg::N_WAKE; i++) begin : g_in
            assign wake[i] = enable && sample
                && (level[i] == sense[i / 2]);
        end
    endgenerate
endmodule // wake_input_detect

/* File: sim/host_model.sv */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    input wire logic spi_ready,
    output logic cs_b,
    output logic cmd_stop,
    output logic cmd_sleep,
    output logic tim_write,
    output logic flag_clear
);
    initial begin
        cs_b = 1'b1;
        cmd_stop = 1'b0;
        cmd_sleep = 1'b0;
        tim_write = 1'b0;
        flag_clear = 1'b0;
    end
    // Whole frame; the command only counts at the closing select edge
    task automatic frame(input logic stop, input logic sleep);
        @(negedge clk);
        cs_b = 1'b0;
        cmd_stop = stop;
        cmd_sleep = sleep;
        @(negedge clk);
        cmd_stop = 1'b0;
        cmd_sleep = 1'b0;
        repeat (3) @(negedge clk);
        cs_b = 1'b1;
        repeat (6) @(negedge clk);
    endtask
    task automatic cs_wake();
        @(negedge clk);
        cs_b = 1'b0;
        repeat (3) @(negedge clk);
        cs_b = 1'b1;
    endtask
    // Holds off until the first-access delay is over, then services
    task automatic service(output bit ok);
        int n;
        ok = 1'b0;
        for (n = 0; n < 4000 && !ok; n++) begin
            @(negedge clk);
            ok = (spi_ready === 1'b1);
        end
        tim_write = ok;
        @(negedge clk);
        tim_write = 1'b0;
    endtask
    task automatic clear_flags();
        @(negedge clk);
        flag_clear = 1'b1;
        @(negedge clk);
        flag_clear = 1'b0;
    endtask
endmodule // host_model

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int RST = 10;
    localparam int NREQ = 2000;
    localparam int BLANK = 20;
    localparam int FSPI = 5;
    localparam int TIMED = 100;
    localparam int CYC = 50;
    localparam int BIAS = 5;
    logic cmd_normal, cmd_standby;
    logic clk, rst_b, window_select, period_select_lo, period_select_hi;
    logic stop_watchdog_enable, bus_wake, overcurrent, vdd_good;
    logic cs_b, cmd_stop, cmd_sleep, tim_write, flag_clear;
    logic [3:0] low_power_control, wake_inputs, input_wake_flag;
    logic [1:0] wake_sense;
    logic mcu_reset_out_b, watchdog_fault_out_b, irq_out_pin_b, spi_ready;
    logic main_regulator_en, high_side_switch, bus_wake_flag;
    sbc_pkg::mode_e mode;
    int err_total = 0;
    int tests_run = 0;
    int per[4] = '{40, 60, 80, 100};
    int k, n, len;
    bit ok;

    host_model i_host_model (.clk(clk), .spi_ready(spi_ready), .cs_b(cs_b),
        .cmd_stop(cmd_stop), .cmd_sleep(cmd_sleep), .tim_write(tim_write),
        .flag_clear(flag_clear));

    sbc_wakeup_watchdog_reset #(.BLANK_CYC(BLANK), .NREQ_CYC(NREQ),
        .RST_CYC(RST), .FIRST_SPI_CYC(FSPI), .TIMED_CYC(TIMED),
        .CYC_CYC(CYC), .BIAS_ON_CYC(BIAS), .WD0_CYC(40), .WD1_CYC(60),
        .WD2_CYC(80), .WD3_CYC(100)) i_sbc_wakeup_watchdog_reset (.clk(clk),
        .rst_b(rst_b), .cs_b(cs_b), .cmd_stop(cmd_stop),
        .cmd_sleep(cmd_sleep), .cmd_normal(cmd_normal),
        .cmd_standby(cmd_standby),
        .tim_write(tim_write), .window_select(window_select),
        .period_select_lo(period_select_lo),
        .period_select_hi(period_select_hi),
        .stop_watchdog_enable(stop_watchdog_enable),
        .low_power_control(low_power_control), .wake_sense(wake_sense),
        .wake_inputs(wake_inputs), .bus_wake(bus_wake),
        .overcurrent(overcurrent), .vdd_good(vdd_good),
        .flag_clear(flag_clear), .mcu_reset_out_b(mcu_reset_out_b),
        .watchdog_fault_out_b(watchdog_fault_out_b),
        .irq_out_pin_b(irq_out_pin_b), .spi_ready(spi_ready),
        .main_regulator_en(main_regulator_en),
        .high_side_switch(high_side_switch), .bus_wake_flag(bus_wake_flag),
        .input_wake_flag(input_wake_flag), .mode(mode));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic await(input sbc_pkg::mode_e m, input int lim);
        int i;
        for (i = 0; i < lim && mode !== m; i++) @(negedge clk);
        check(32'(mode), 32'(m));
        if (mode !== m) stop_test();
    endtask
    task automatic normal();
        i_host_model.service(ok);
        check(32'(ok), 32'h1);
        await(sbc_pkg::M_NORMAL, 5);
    endtask
    // Pulse may not overlap reset; the bus stays shut right after it
    task automatic irq_pulse();
        int i;
        bit clash;
        clash = 1'b0;
        len = 0;
        for (i = 0; i < 20 && irq_out_pin_b !== 1'b0; i++) @(negedge clk);
        while (irq_out_pin_b === 1'b0 && len < 3000) begin
            clash |= (mcu_reset_out_b !== 1'b1);
            len++;
            @(negedge clk);
        end
        check(32'(clash), 32'h0);
        check(32'(spi_ready), 32'h0);
        check(32'(len), 32'(sbc_pkg::IRQ_CYC));
    endtask

    initial begin
        rst_b = 1'b0;
        cmd_normal = 1'b0;
        cmd_standby = 1'b0;
        window_select = 1'b1;
        {period_select_hi, period_select_lo} = 2'b00;
        stop_watchdog_enable = 1'b0;
        bus_wake = 1'b0;
        overcurrent = 1'b0;
        vdd_good = 1'b0;
        low_power_control = 4'h0;
        wake_sense = 2'b01;
        wake_inputs = 4'b1100;
        repeat (4) @(negedge clk);
        check(32'(mcu_reset_out_b), 32'h0);
        rst_b = 1'b1;
        repeat (30) @(negedge clk);
        check(32'(mcu_reset_out_b), 32'h0);
        vdd_good = 1'b1;
        await(sbc_pkg::M_NREQ, RST + 20);
        repeat (2) @(negedge clk);
        check(32'(mcu_reset_out_b), 32'h1);
        normal();
        // Early service lands in the closed half
        i_host_model.service(ok);
        await(sbc_pkg::M_RESET, 5);
        check(32'(watchdog_fault_out_b), 32'h0);
        for (n = 0; n < 100 && mcu_reset_out_b !== 1'b1; n++) @(negedge clk);
        check(32'(n >= RST - 2 && n <= RST + 4), 32'h1);
        check(32'(watchdog_fault_out_b), 32'h0);
        normal();
        check(32'(watchdog_fault_out_b), 32'h1);
        cmd_standby = 1'b1;
        @(negedge clk);
        cmd_standby = 1'b0;
        check(32'(mode), 32'(sbc_pkg::M_STANDBY));
        cmd_normal = 1'b1;
        @(negedge clk);
        cmd_normal = 1'b0;
        check(32'(mode), 32'(sbc_pkg::M_NORMAL));
        repeat (28) @(negedge clk);
        normal();
        await(sbc_pkg::M_RESET, 45);
        check(32'(watchdog_fault_out_b), 32'h0);
        await(sbc_pkg::M_NREQ, RST + 5);
        window_select = 1'b0;
        for (k = 0; k < 4; k++) begin
            {period_select_hi, period_select_lo} = k[1:0];
            normal();
            for (n = 0; n < 200 && mcu_reset_out_b !== 1'b0; n++)
                @(negedge clk);
            check(32'(n >= per[k] - 3 && n <= per[k] + 3), 32'h1);
            await(sbc_pkg::M_NREQ, RST + 5);
        end
        normal();
        // Wake sources: bus, input, select, overcurrent, timed
        for (k = 0; k < 5; k++) begin
            low_power_control = (k == 4) ? 4'b0010 : 4'h0;
            i_host_model.frame(1'b1, 1'b0);
            check(32'(mode), 32'(sbc_pkg::M_STOP));
            case (k)
                0: bus_wake = 1'b1;
                1: wake_inputs = 4'b1000;
                2: i_host_model.cs_wake();
                3: begin
                    overcurrent = 1'b1;
                    repeat (10) @(negedge clk);
                    check(32'(mode), 32'(sbc_pkg::M_STOP));
                end
                default: ;
            endcase
            await(sbc_pkg::M_NREQ, 150);
            irq_pulse();
            check(32'(bus_wake_flag), 32'(k == 0));
            check(32'(input_wake_flag), (k == 1) ? 32'h4 : 32'h0);
            bus_wake = 1'b0;
            overcurrent = 1'b0;
            wake_inputs = 4'b1100;
            low_power_control = 4'h0;
            normal();
            i_host_model.clear_flags();
        end
        low_power_control = 4'b1001;
        i_host_model.frame(1'b1, 1'b0);
        for (n = 0; n < 80 && high_side_switch !== 1'b1; n++) @(negedge clk);
        check(32'(high_side_switch), 32'h1);
        i_host_model.cs_wake();
        await(sbc_pkg::M_NREQ, 10);
        irq_pulse();
        low_power_control = 4'h0;
        normal();
        {period_select_hi, period_select_lo} = 2'b00;
        stop_watchdog_enable = 1'b1;
        normal();
        i_host_model.frame(1'b1, 1'b0);
        for (n = 0; n < 100 && mcu_reset_out_b !== 1'b0; n++) begin
            @(negedge clk);
            check(32'(irq_out_pin_b), 32'h1);
        end
        await(sbc_pkg::M_NREQ, RST + 5);
        stop_watchdog_enable = 1'b0;
        {period_select_hi, period_select_lo} = 2'b11;
        normal();
        i_host_model.frame(1'b0, 1'b1);
        await(sbc_pkg::M_SLEEP, 5);
        check(32'(main_regulator_en), 32'h0);
        i_host_model.cs_wake();
        await(sbc_pkg::M_RESET, 10);
        @(negedge clk);
        check(32'(main_regulator_en), 32'h1);
        check(32'(mcu_reset_out_b), 32'h0);
        await(sbc_pkg::M_NREQ, RST + 5);
        await(sbc_pkg::M_SLEEP, NREQ + 10);
        i_host_model.cs_wake();
        await(sbc_pkg::M_NREQ, RST + 20);
        normal();
        vdd_good = 1'b0;
        repeat (5) @(negedge clk);
        check(32'(mcu_reset_out_b), 32'h0);
        check(32'(watchdog_fault_out_b), 32'h1);
        vdd_good = 1'b1;
        await(sbc_pkg::M_NREQ, RST + 20);
        await(sbc_pkg::M_RESET, NREQ + 10);
        stop_test();
    end
endmodule // testbench
